// [common/tos_pkg.sv]
// constants shared by the transmitter on/off sequencer files
// assumes a 25 MHz core clock and a 1 ms sequencing tick
package tos_pkg;
  // clock and tick
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1_000_000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_MS       = 1;
  // step-start timing
  localparam int STEP_START_MS    = 100;
  localparam int STEP_RELEASE_MS  = 160;
  localparam int STEP_START_TICKS = STEP_START_MS / TICK_MS;
  localparam int STEP_REL_TICKS   = STEP_RELEASE_MS / TICK_MS;
  localparam int STEP_CNT_W       = 8;
  // warm-up, cool-down and debounce defaults
  localparam int WARMUP_MS    = 2000;
  localparam int COOLDOWN_MS  = 3000;
  localparam int DEBOUNCE_MS  = 10;
  localparam int TIMER_W      = 16;
  localparam int DEB_W        = 4;
  // conditioned input vector positions
  localparam int IN_FIL_ON    = 0;
  localparam int IN_FIL_OFF   = 1;
  localparam int IN_HV_ON     = 2;
  localparam int IN_HV_OFF    = 3;
  localparam int IN_RDIS      = 4;
  localparam int IN_R_FIL_ON  = 5;
  localparam int IN_R_FIL_OFF = 6;
  localparam int IN_R_HV_ON   = 7;
  localparam int IN_R_HV_OFF  = 8;
  localparam int IN_ILK       = 9;
  localparam int IN_FAILSAFE  = 10;
  localparam int IN_AIR       = 11;
  localparam int IN_OVERLOAD  = 12;
  localparam int IN_FREQ_LOCK = 13;
  localparam int IN_POLARITY  = 14;
  localparam int IN_MAINS_OK  = 15;
  localparam int NUM_IN       = 16;
  localparam int NUM_BTN      = 9;
  // plate supply step-start states
  typedef enum logic [1:0] {
    PV_IDLE = 2'h0,
    PV_STEP = 2'h1,
    PV_BOTH = 2'h2,
    PV_RUN  = 2'h3
  } tos_pv_t;
endpackage : tos_pkg

// [common/tos_link_if.sv]
// tick and conditioned inputs passed between the sequencer's own modules
// assumes all parties run on core_clk_in
`timescale 1ns/100ps
`default_nettype none
interface tos_link_if;
  logic                       tick;
  logic                       tick_clr;
  logic [tos_pkg::NUM_IN-1:0] lvl;
  modport tick_src (output tick, input tick_clr);
  modport cond_src (output lvl, input tick);
  modport seq      (input tick, input lvl, output tick_clr);
endinterface : tos_link_if
`default_nettype wire

// [core/tos_tick_gen.sv]
// fixed sequencing tick derived from the core clock
// assumes tick_clr comes from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module tos_tick_gen #(
  parameter int CYCLES = tos_pkg::TICK_CYCLES
) (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  tos_link_if.tick_src link
);
  localparam int CW = $clog2(CYCLES);

  if (CYCLES < 2) $error("tick period must be at least two cycles");

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tos_tick_t;

  tos_tick_t st_r;
  tos_tick_t st_nxt;

  // a clear restarts the phase so the step-start intervals are whole ticks
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (link.tick_clr) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == CW'(CYCLES - 1)) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) st_r <= '0;
    else          st_r <= st_nxt;
  end

  assign link.tick = st_r.tick;
endmodule : tos_tick_gen
`default_nettype wire

// [core/tos_input_cond.sv]
// two-flop synchroniser and tick-based debounce for every pin input
// assumes raw_in are asynchronous pins; tick is one cycle wide
`timescale 1ns/100ps
`default_nettype none
module tos_input_cond #(
  parameter int N   = tos_pkg::NUM_IN,
  parameter int DEB = tos_pkg::DEBOUNCE_MS / tos_pkg::TICK_MS
) (
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  input  wire logic [N-1:0] raw_in,
  tos_link_if.cond_src      link
);
  localparam int DW = tos_pkg::DEB_W;

  if (DEB < 1 || DEB >= (1 << DW)) $error("debounce count out of range");

  typedef struct packed {
    logic [N-1:0]         s1;
    logic [N-1:0]         s2;
    logic [N-1:0]         lvl;
    logic [N-1:0][DW-1:0] cnt;
  } tos_cond_t;

  tos_cond_t st_r;
  tos_cond_t st_nxt;

  // a level is accepted only after it has held across DEB tick pulses
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = raw_in;
    st_nxt.s2 = st_r.s1;
    for (int i = 0; i < N; i++) begin
      if (st_r.s2[i] == st_r.lvl[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (link.tick) begin
        if (st_r.cnt[i] == DW'(DEB - 1)) begin
          st_nxt.lvl[i] = st_r.s2[i];
          st_nxt.cnt[i] = '0;
        end else begin
          st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) st_r <= '0;
    else          st_r <= st_nxt;
  end

  assign link.lvl = st_r.lvl;
endmodule : tos_input_cond
`default_nettype wire

// [core/tos_sequencer.sv]
// transmitter on/off sequencer: command latches, blower, filament,
// plate step-start, exciter mute, cool-down and remote merge
// assumes all pins asynchronous; reset_in is the memory-loss reset only
//
// Behaviour
// - filament/plate presses latch and light lamp
// - plate-on alone runs the whole start
// - blower runs on command with interlock closed
// - interlock lamp follows interlock chain
// - airflow closure: blower lamp, warm-up, filament on
// - plate on only with every permissive met
// - failsafe lamp follows failsafe interlock
// - plate status lamp shows plate supply on
// - plate start energizes step driver first
// - start driver follows step by 100 ms
// - step driver releases after 160 ms
// - exciter enable coincides with plate start
// - plate-off drops plate and both lamps
// - filament-off mutes, drops supplies, starts cool-down
// - cool-down expiry stops blower and lamp
// - remote commands only while remote enabled
// - front-panel commands accepted whenever mains is ok
// - remote command ORs with local button
// - remote active level set by header
// - remote status outputs always driven
// - latched state kept through mains failure
// - open failsafe drops only plate supply
`timescale 1ns/100ps
`default_nettype none
module tos_sequencer #(
  parameter int TICK_CYCLES = tos_pkg::TICK_CYCLES,
  parameter int WARMUP_MS   = tos_pkg::WARMUP_MS,
  parameter int COOLDOWN_MS = tos_pkg::COOLDOWN_MS
) (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  // front-panel pushbuttons
  input  wire logic       fil_on_btn_in,
  input  wire logic       fil_off_btn_in,
  input  wire logic       hv_on_btn_in,
  input  wire logic       hv_off_btn_in,
  input  wire logic       remote_disable_btn_in,
  // remote commands
  input  wire logic       rem_fil_on_in,
  input  wire logic       rem_fil_off_in,
  input  wire logic       rem_hv_on_in,
  input  wire logic       rem_hv_off_in,
  input  wire logic       remote_polarity_select_header_in,
  // interlocks and transmitter status
  input  wire logic       interlock_closed_in,
  input  wire logic       failsafe_closed_in,
  input  wire logic       airflow_closed_in,
  input  wire logic       overload_in,
  input  wire logic       exciter_frequency_lock_in,
  input  wire logic       mains_ok_in,
  // power stage drivers
  output logic            blower_out,
  output logic            filament_out,
  output logic            plate_on_out,
  output logic            step_driver_out,
  output logic            start_driver_out,
  output logic            exciter_enable_out,
  output logic            exciter_mute_out,
  // front-panel lamps
  output logic            fil_on_lamp_out,
  output logic            hv_on_lamp_out,
  output logic            remote_disable_lamp_out,
  output logic            interlock_lamp_out,
  output logic            failsafe_lamp_out,
  output logic            blower_lamp_out,
  output logic            filament_lamp_out,
  output logic            hv_status_lamp_out,
  // remote status
  output logic [5:0]      remote_status_out
);
  localparam int TW = tos_pkg::TIMER_W;
  localparam int SW = tos_pkg::STEP_CNT_W;

  if (WARMUP_MS < 1 || WARMUP_MS >= (1 << TW)) $error("warm-up out of range");
  if (COOLDOWN_MS < 1 || COOLDOWN_MS >= (1 << TW)) $error("cool-down out of range");
  if (tos_pkg::STEP_REL_TICKS >= (1 << SW)) $error("step counter too narrow");

  typedef struct packed {
    logic                         fil_cmd;
    logic                         hv_cmd;
    logic                         run;
    logic                         rdis;
    logic                         ilk_prev;
    logic [tos_pkg::NUM_BTN-1:0]  btn_prev;
    logic                         warm_done;
    logic [TW-1:0]                warm_cnt;
    logic                         cool_act;
    logic [TW-1:0]                cool_cnt;
    tos_pkg::tos_pv_t             pv;
    logic [SW-1:0]                step_cnt;
    logic                         blower;
    logic                         fil;
    logic                         plate;
    logic                         step;
    logic                         start;
    logic                         blower_lamp;
    logic                         ilk_lamp;
    logic                         fs_lamp;
  } tos_seq_t;

  tos_seq_t st_r;
  tos_seq_t st_nxt;

  tos_link_if link ();

  logic [tos_pkg::NUM_IN-1:0] raw;
  assign raw = {mains_ok_in, remote_polarity_select_header_in,
                exciter_frequency_lock_in, overload_in, airflow_closed_in,
                failsafe_closed_in, interlock_closed_in, rem_hv_off_in,
                rem_hv_on_in, rem_fil_off_in, rem_fil_on_in,
                remote_disable_btn_in, hv_off_btn_in, hv_on_btn_in,
                fil_off_btn_in, fil_on_btn_in};

  tos_input_cond #(
    .N   (tos_pkg::NUM_IN),
    .DEB (tos_pkg::DEBOUNCE_MS / tos_pkg::TICK_MS)
  ) u_cond (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .raw_in      (raw),
    .link        (link)
  );

  tos_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .link        (link)
  );

  // header high selects active-high remote inputs, low selects active-ground
  function automatic logic rem_active(input logic lvl, input logic pol_high);
    rem_active = ~(lvl ^ pol_high);
  endfunction : rem_active

  logic [tos_pkg::NUM_IN-1:0]  lv;
  logic [tos_pkg::NUM_BTN-1:0] btn_now;
  logic [tos_pkg::NUM_BTN-1:0] rise;
  logic                        mains;
  logic                        rem_en;
  logic                        p_fil_on;
  logic                        p_fil_off;
  logic                        p_hv_on;
  logic                        p_hv_off;

  assign lv      = link.lvl;
  assign mains   = lv[tos_pkg::IN_MAINS_OK];
  assign btn_now = {rem_active(lv[tos_pkg::IN_R_HV_OFF], lv[tos_pkg::IN_POLARITY]),
                    rem_active(lv[tos_pkg::IN_R_HV_ON], lv[tos_pkg::IN_POLARITY]),
                    rem_active(lv[tos_pkg::IN_R_FIL_OFF], lv[tos_pkg::IN_POLARITY]),
                    rem_active(lv[tos_pkg::IN_R_FIL_ON], lv[tos_pkg::IN_POLARITY]),
                    lv[tos_pkg::IN_RDIS:tos_pkg::IN_FIL_ON]};
  assign rise    = btn_now & ~st_r.btn_prev;
  assign rem_en  = ~st_r.rdis;
  // local always counts, remote only while enabled; presses during a mains loss are dropped
  assign p_fil_on  = mains & (rise[tos_pkg::IN_FIL_ON]
                     | (rem_en & rise[tos_pkg::IN_R_FIL_ON]));
  assign p_fil_off = mains & (rise[tos_pkg::IN_FIL_OFF]
                     | (rem_en & rise[tos_pkg::IN_R_FIL_OFF]));
  assign p_hv_on   = mains & (rise[tos_pkg::IN_HV_ON]
                     | (rem_en & rise[tos_pkg::IN_R_HV_ON]));
  assign p_hv_off  = mains & (rise[tos_pkg::IN_HV_OFF]
                     | (rem_en & rise[tos_pkg::IN_R_HV_OFF]));

  always_comb begin
    logic ilk;
    logic fs;
    logic air;
    logic run_now;
    logic run_nxt;
    logic permit;
    ilk     = lv[tos_pkg::IN_ILK];
    fs      = lv[tos_pkg::IN_FAILSAFE];
    air     = lv[tos_pkg::IN_AIR];
    run_now = st_r.run;
    run_nxt = 1'b0;
    permit  = 1'b0;
    st_nxt  = st_r;
    link.tick_clr    = 1'b0;
    st_nxt.btn_prev  = btn_now;
    st_nxt.ilk_prev  = ilk;
    if (rise[tos_pkg::IN_RDIS]) begin
      st_nxt.rdis = ~st_r.rdis;
    end
    // clears first so a press in the same cycle wins
    if (p_hv_off) begin
      st_nxt.hv_cmd = 1'b0;
    end
    if (p_fil_off) begin
      st_nxt.hv_cmd  = 1'b0;
      st_nxt.fil_cmd = 1'b0;
      st_nxt.run     = 1'b0;
    end
    // an opening interlock needs a manual restart
    if (st_r.ilk_prev & ~ilk) begin
      st_nxt.hv_cmd  = 1'b0;
      st_nxt.fil_cmd = 1'b0;
      st_nxt.run     = 1'b0;
    end
    if (p_fil_on) begin
      st_nxt.fil_cmd = 1'b1;
      st_nxt.run     = 1'b1;
    end
    if (p_hv_on) begin
      st_nxt.hv_cmd = 1'b1;
      st_nxt.run    = 1'b1;
    end
    // run latch: a plate-off leaves filament and blower up, only a filament-off or an opening interlock clears it
    run_nxt = st_nxt.run;
    // cool-down starts when a lit filament loses its command
    if (run_now & ~run_nxt & st_r.fil) begin
      st_nxt.cool_act = 1'b1;
      st_nxt.cool_cnt = '0;
    end else if (run_nxt) begin
      st_nxt.cool_act = 1'b0;
    end else if (st_r.cool_act & link.tick & mains) begin
      if (st_r.cool_cnt == TW'(COOLDOWN_MS - 1)) begin
        st_nxt.cool_act = 1'b0;
      end else begin
        st_nxt.cool_cnt = st_r.cool_cnt + 1'b1;
      end
    end
    // warm-up holds during a mains loss but clears when mains returns, before the filament relights
    if (st_r.fil) begin
      if (link.tick & ~st_r.warm_done) begin
        if (st_r.warm_cnt == TW'(WARMUP_MS - 1)) begin
          st_nxt.warm_done = 1'b1;
        end else begin
          st_nxt.warm_cnt = st_r.warm_cnt + 1'b1;
        end
      end
    end else if (mains) begin
      st_nxt.warm_done = 1'b0;
      st_nxt.warm_cnt  = '0;
    end
    st_nxt.blower = mains & ilk & (run_nxt | st_nxt.cool_act);
    st_nxt.fil    = st_nxt.blower & air & run_nxt;
    permit = st_nxt.hv_cmd & st_r.warm_done & ~lv[tos_pkg::IN_OVERLOAD] & ilk & fs
             & air & lv[tos_pkg::IN_FREQ_LOCK] & st_nxt.fil;
    if (!permit) begin
      st_nxt.pv       = tos_pkg::PV_IDLE;
      st_nxt.step_cnt = '0;
    end else begin
      case (st_r.pv)
        tos_pkg::PV_IDLE: begin
          st_nxt.pv       = tos_pkg::PV_STEP;
          st_nxt.step_cnt = '0;
          link.tick_clr   = 1'b1;
        end
        tos_pkg::PV_STEP: begin
          if (link.tick) begin
            st_nxt.step_cnt = st_r.step_cnt + 1'b1;
            if (st_r.step_cnt == SW'(tos_pkg::STEP_START_TICKS - 1)) begin
              st_nxt.pv = tos_pkg::PV_BOTH;
            end
          end
        end
        tos_pkg::PV_BOTH: begin
          if (link.tick) begin
            st_nxt.step_cnt = st_r.step_cnt + 1'b1;
            if (st_r.step_cnt == SW'(tos_pkg::STEP_REL_TICKS - 1)) begin
              st_nxt.pv = tos_pkg::PV_RUN;
            end
          end
        end
        tos_pkg::PV_RUN: begin
          st_nxt.pv = tos_pkg::PV_RUN;
        end
        default: begin
          st_nxt.pv = tos_pkg::PV_IDLE;
        end
      endcase
    end
    st_nxt.plate = permit;
    st_nxt.step  = permit & (st_nxt.pv == tos_pkg::PV_STEP
                             || st_nxt.pv == tos_pkg::PV_BOTH);
    st_nxt.start = permit & (st_nxt.pv == tos_pkg::PV_BOTH
                             || st_nxt.pv == tos_pkg::PV_RUN);
    st_nxt.blower_lamp = st_nxt.blower & air;
    st_nxt.ilk_lamp    = ilk;
    st_nxt.fs_lamp     = fs;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) st_r <= '0;
    else          st_r <= st_nxt;
  end

  assign blower_out              = st_r.blower;
  assign filament_out            = st_r.fil;
  assign plate_on_out            = st_r.plate;
  assign step_driver_out         = st_r.step;
  assign start_driver_out        = st_r.start;
  assign exciter_enable_out      = st_r.plate;
  assign exciter_mute_out        = ~st_r.plate;
  assign fil_on_lamp_out         = st_r.fil_cmd;
  assign hv_on_lamp_out          = st_r.hv_cmd;
  assign remote_disable_lamp_out = st_r.rdis;
  assign interlock_lamp_out      = st_r.ilk_lamp;
  assign failsafe_lamp_out       = st_r.fs_lamp;
  assign blower_lamp_out         = st_r.blower_lamp;
  assign filament_lamp_out       = st_r.fil;
  assign hv_status_lamp_out      = st_r.plate;
  // status leaves the block whatever the remote-disable setting
  assign remote_status_out = {st_r.plate, st_r.fil, st_r.blower_lamp,
                              st_r.fs_lamp, st_r.ilk_lamp, st_r.rdis};

  chk_cmd_latch: assert property (@(posedge core_clk_in) disable iff (reset_in)
    p_fil_on |=> fil_on_lamp_out)
    else $error("filament press not latched");
  chk_one_button: assert property (@(posedge core_clk_in) disable iff (reset_in)
    p_hv_on && lv[tos_pkg::IN_ILK] && !st_r.ilk_prev == 1'b0 |=> blower_out)
    else $error("plate press alone did not start blower");
  chk_blower_gate: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(blower_out) |-> $past(lv[tos_pkg::IN_ILK]) && $past(mains))
    else $error("blower started with interlock open");
  chk_ilk_lamp: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ##1 interlock_lamp_out == $past(lv[tos_pkg::IN_ILK]))
    else $error("interlock lamp wrong");
  chk_fil_air: assert property (@(posedge core_clk_in) disable iff (reset_in)
    filament_out |-> blower_out && blower_lamp_out && $past(lv[tos_pkg::IN_AIR]))
    else $error("filament on without airflow");
  chk_plate_permit: assert property (@(posedge core_clk_in) disable iff (reset_in)
    plate_on_out |-> $past(st_r.warm_done && !lv[tos_pkg::IN_OVERLOAD]
                           && lv[tos_pkg::IN_FAILSAFE] && lv[tos_pkg::IN_FREQ_LOCK]))
    else $error("plate on without permissives");
  chk_fs_lamp: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(lv[tos_pkg::IN_FAILSAFE]) |=> failsafe_lamp_out)
    else $error("failsafe lamp not lit");
  chk_step_first: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(plate_on_out) |-> step_driver_out && !start_driver_out)
    else $error("step driver not first");
  chk_start_delay: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(start_driver_out) |-> step_driver_out
      && st_r.step_cnt == SW'(tos_pkg::STEP_START_TICKS))
    else $error("start driver timing wrong");
  chk_step_release: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $fell(step_driver_out) && plate_on_out |-> start_driver_out
      && st_r.step_cnt == SW'(tos_pkg::STEP_REL_TICKS))
    else $error("step release timing wrong");
  chk_exc_same: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(plate_on_out) |-> $rose(exciter_enable_out) && !exciter_mute_out)
    else $error("exciter not enabled with plate");
  chk_fil_off: assert property (@(posedge core_clk_in) disable iff (reset_in)
    p_fil_off && !p_fil_on && !p_hv_on |=> !fil_on_lamp_out && !plate_on_out
      && !filament_out && exciter_mute_out)
    else $error("filament off sequence incomplete");
  chk_remote_gate: assert property (@(posedge core_clk_in) disable iff (reset_in)
    st_r.rdis && !rise[tos_pkg::IN_FIL_ON] && !p_fil_off && st_r.ilk_prev
      && lv[tos_pkg::IN_ILK] |=> fil_on_lamp_out == $past(fil_on_lamp_out))
    else $error("remote command taken while disabled");
endmodule : tos_sequencer
`default_nettype wire

// [testbench/tos_power_stage_model.sv]
// model of the transmitter power stages seen by the sequencer
// assumes the bench clock and reset; air pressure builds only while the blower runs
`timescale 1ns/100ps
`default_nettype none
module tos_power_stage_model #(
  parameter int AIR_DLY = 8
) (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic blower_in,
  output logic      airflow_closed_out,
  output logic      freq_lock_out
);
  int air_cnt_r;
  // pressure decays at once when the blower stops, so the switch opens too
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !blower_in) begin
      air_cnt_r <= 0;
    end else if (air_cnt_r < AIR_DLY) begin
      air_cnt_r <= air_cnt_r + 1;
    end
    freq_lock_out <= !reset_in;
  end
  assign airflow_closed_out = (air_cnt_r == AIR_DLY);
endmodule : tos_power_stage_model
`default_nettype wire

// [testbench/test_transmitter_on_off_sequencer.sv]
// self-checking bench for the on/off sequencer
// assumes a short tick (4 cycles), 5-tick warm-up and cool-down, 10-tick debounce
`timescale 1ns/100ps
`default_nettype none
module test_transmitter_on_off_sequencer;
  localparam int TK = 4;
  logic       core_clk_in, reset_in, ilk, fsafe, pol, air, lock, ovl, mains;
  logic [8:0] btn;
  logic       blow, fil, plate, stp, strt, ex_en, mute;
  logic       fon_l, hon_l, rdis_l, ilk_l, fs_l, blow_l, fil_l, hv_l;
  logic [5:0] rstat;
  logic [4:0] mon;
  int         n_mismatch, checks, cyc, n;
  assign mon = {blow, fil, plate, stp, strt};
  tos_sequencer #(.TICK_CYCLES(TK), .WARMUP_MS(5), .COOLDOWN_MS(5)) i_tos_sequencer (
    .core_clk_in(core_clk_in), .reset_in(reset_in),
    .fil_on_btn_in(btn[0]), .fil_off_btn_in(btn[1]), .hv_on_btn_in(btn[2]),
    .hv_off_btn_in(btn[3]), .remote_disable_btn_in(btn[4]),
    .rem_fil_on_in(btn[5] ~^ pol), .rem_fil_off_in(btn[6] ~^ pol),
    .rem_hv_on_in(btn[7] ~^ pol), .rem_hv_off_in(btn[8] ~^ pol),
    .remote_polarity_select_header_in(pol),
    .interlock_closed_in(ilk), .failsafe_closed_in(fsafe), .airflow_closed_in(air),
    .overload_in(ovl), .exciter_frequency_lock_in(lock), .mains_ok_in(mains),
    .blower_out(blow), .filament_out(fil), .plate_on_out(plate), .step_driver_out(stp),
    .start_driver_out(strt), .exciter_enable_out(ex_en), .exciter_mute_out(mute),
    .fil_on_lamp_out(fon_l), .hv_on_lamp_out(hon_l), .remote_disable_lamp_out(rdis_l),
    .interlock_lamp_out(ilk_l), .failsafe_lamp_out(fs_l), .blower_lamp_out(blow_l),
    .filament_lamp_out(fil_l), .hv_status_lamp_out(hv_l), .remote_status_out(rstat));
  tos_power_stage_model i_tos_power_stage_model (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .blower_in(blow),
    .airflow_closed_out(air), .freq_lock_out(lock));

  task automatic step(input int c);
    repeat (c) @(posedge core_clk_in);
    #2;
  endtask : step
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // a press must outlast the debounce, then a release must too
  task automatic press(input int b);
    btn[b] = 1'b1;
    step(60);
    btn[b] = 1'b0;
    step(60);
  endtask : press
  task automatic wait_lvl(input int b, input logic v, output int c);
    c = 0;
    while (mon[b] !== v && c < 3000) begin
      step(1);
      c++;
    end
  endtask : wait_lvl
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      $display("FAIL at %0t: run too long", $time);
      give_verdict();
    end
  end

  initial begin
    n_mismatch = 0; checks = 0; cyc = 0;
    reset_in = 1'b1; btn = 9'h000; ilk = 1'b1; fsafe = 1'b1; pol = 1'b0;
    ovl = 1'b0; mains = 1'b1;
    step(8);
    reset_in = 1'b0;
    step(60);
    chk(ilk_l, 1'b1);
    chk(fs_l, 1'b1);
    chk({plate, mute}, 2'h1);
    // hold the press until the plate rises so step timing counts from that edge
    btn[2] = 1'b1;
    wait_lvl(2, 1'b1, n);
    btn[2] = 1'b0;
    chk(hon_l, 1'b1);
    chk(blow, 1'b1);
    chk({fil, fil_l, blow_l}, 3'h7);
    chk({plate, ex_en, mute, hv_l, strt, stp}, 6'h35);
    wait_lvl(0, 1'b1, n);
    chk(n >= 100 * TK - TK && n <= 100 * TK + TK, 1'b1);
    wait_lvl(1, 1'b0, n);
    chk(n >= 60 * TK - TK && n <= 60 * TK + TK, 1'b1);
    chk(strt, 1'b1);
    fsafe = 1'b0;
    step(60);
    chk({plate, fil, fs_l, hv_l}, 4'h4);
    fsafe = 1'b1;
    wait_lvl(2, 1'b1, n);
    chk({stp, strt}, 2'h2);
    press(3);
    chk({plate, hon_l, hv_l, mute, fil}, 5'h03);
    press(4);
    chk(rstat, 6'h1f);
    press(7);
    chk(plate, 1'b0);
    press(4);
    chk(rdis_l, 1'b0);
    press(7);
    chk(plate, 1'b1);
    ovl = 1'b1;
    step(60);
    chk(plate, 1'b0);
    ovl = 1'b0;
    wait_lvl(2, 1'b1, n);
    chk(plate, 1'b1);
    // a mains loss drops every driver but keeps the latched commands
    mains = 1'b0;
    step(60);
    chk({blow, fil, plate, hon_l}, 4'h1);
    mains = 1'b1;
    wait_lvl(2, 1'b1, n);
    chk({plate, hon_l}, 2'h3);
    // remote pins and strap flip together, so no false press may appear
    pol = 1'b1;
    step(60);
    chk(plate, 1'b1);
    press(8);
    chk({plate, hon_l}, 2'h0);
    press(4);
    press(0);
    chk(fon_l, 1'b1);
    btn[1] = 1'b1;
    wait_lvl(3, 1'b0, n);
    chk({mute, plate, fil, fon_l, fil_l, blow}, 6'h21);
    btn[1] = 1'b0;
    wait_lvl(4, 1'b0, n);
    chk({n >= 4 * TK && n <= 5 * TK, blow_l}, 2'h2);
    ilk = 1'b0;
    step(60);
    chk({ilk_l, blow}, 2'h0);
    press(0);
    chk({fon_l, blow}, 2'h2);
    ilk = 1'b1;
    step(60);
    chk({ilk_l, blow}, 2'h3);
    give_verdict();
  end
endmodule : test_transmitter_on_off_sequencer
`default_nettype wire
